// File: ats_params.svh
// constants for the analog test pin sequencer
// assumes inclusion by bare name from the package and modules
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH
`define ATS_NUM_CH   14
`define ATS_IDX_W    4
`define ATS_IDX_ZERO 4'h0
`endif

// File: ats_pkg.sv
// types for the analog test pin sequencer
// assumes ats_params.svh is on the include path
`include "ats_params.svh"
package ats_pkg;
    // gray order along idle, arm, tx, gap, rx, done
    typedef enum logic [2:0] {
        ATS_IDLE = 3'h0,
        ATS_ARM  = 3'h1,
        ATS_TX   = 3'h3,
        ATS_GAP  = 3'h2,
        ATS_RX   = 3'h6,
        ATS_DONE = 3'h7
    } ats_state_t;
    typedef logic [`ATS_IDX_W-1:0] ats_idx_t;
endpackage : ats_pkg

// File: ats_route.sv
// one-hot channel route decode from sequencer state and index
// assumes the sequencer drives state and idx from flip-flops
`include "ats_params.svh"
module ats_route
    import ats_pkg::*;
#(
    parameter int NUM_CH = `ATS_NUM_CH
) (
    ats_sel_if.route sel
);
    wire in_tx = (sel.state == ATS_TX);
    wire in_rx = (sel.state == ATS_RX);

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
            wire hit = (sel.idx == ats_idx_t'(g));
            assign sel.tx_sel[g] = in_tx & hit;
            assign sel.rx_sel[g] = in_rx & hit;
        end
    endgenerate
endmodule : ats_route

// File: ats_sel_if.sv
// carrier between the sequencer and its route decoder
// assumes ats_pkg is compiled first
`include "ats_params.svh"
interface ats_sel_if;
    import ats_pkg::*;
    ats_state_t state;
    ats_idx_t   idx;
    logic [`ATS_NUM_CH-1:0] tx_sel;
    logic [`ATS_NUM_CH-1:0] rx_sel;
    modport seq   (output state, output idx, input tx_sel, input rx_sel);
    modport route (input state, input idx, output tx_sel, output rx_sel);
endinterface : ats_sel_if

// File: ats_seq.sv
// analog test pin sequencer: steps tip/ring taps of each channel onto the test pins
// assumes seq_clk and seq_ctl_n are synchronous to clock and far slower than it
// Contract
// - with sequence clock running, control low starts the stepping sequence.
// - first falling sequence edge after control low resets the sequence, no tap.
// - second falling edge taps channel zero transmit tip and ring.
// - seventeenth falling edge taps channel zero receive tip and ring.
// - control high after pulse thirty disconnects taps, channels return normal.
// - control input is the sequencer reset, sequence clock its clock.
`include "ats_params.svh"
module ats_seq
    import ats_pkg::*;
#(
    parameter int NUM_CH = `ATS_NUM_CH
) (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              seq_clk,
    input  wire logic              seq_ctl_n,
    output logic [NUM_CH-1:0]      tx_tap_en,
    output logic [NUM_CH-1:0]      rx_tap_en,
    output logic                   test_pins_on,
    output logic                   test_mode,
    output logic                   seq_done
);
    ////////////////////////////////////////////////////////////////////////////
    // sequence clock edge detect
    logic       seq_clk_reg;
    ats_state_t state_reg;
    ats_state_t state_next;
    ats_idx_t   idx_reg;
    ats_idx_t   idx_next;

    wire      seq_fall = seq_clk_reg & ~seq_clk;
    wire      last_ch  = (idx_reg == ats_idx_t'(NUM_CH - 1));
    ats_idx_t idx_inc;
    assign idx_inc = idx_reg + ats_idx_t'(1);

    ats_sel_if sel ();
    assign sel.state = state_reg;
    assign sel.idx   = idx_reg;

    ats_route #(.NUM_CH(NUM_CH)) u_route (
        .sel (sel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // step sequencing, advanced only on falling sequence edges
    always_comb begin
        state_next = state_reg;
        idx_next   = idx_reg;
        if (seq_ctl_n) begin
            // control high holds the sequencer in reset
            state_next = ATS_IDLE;
            idx_next   = `ATS_IDX_ZERO;
        end else if (seq_fall) begin
            case (state_reg)
                ATS_IDLE: begin
                    state_next = ATS_ARM;
                    idx_next   = `ATS_IDX_ZERO;
                end
                ATS_ARM: begin
                    state_next = ATS_TX;
                end
                ATS_TX: begin
                    if (last_ch) begin
                        state_next = ATS_GAP;
                        idx_next   = `ATS_IDX_ZERO;
                    end else begin
                        idx_next = idx_inc;
                    end
                end
                ATS_GAP: begin
                    state_next = ATS_RX;
                end
                ATS_RX: begin
                    if (last_ch) begin
                        state_next = ATS_DONE;
                    end else begin
                        idx_next = idx_inc;
                    end
                end
                ATS_DONE: begin
                    // parked until control returns high; extra edges are ignored
                    state_next = ATS_DONE;
                end
                default: begin
                    state_next = ATS_IDLE;
                    idx_next   = `ATS_IDX_ZERO;
                end
            endcase
        end
    end

    wire any_tap   = (|sel.tx_sel) | (|sel.rx_sel);
    wire seq_activ = (state_next != ATS_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // registers; taps one clock after the state, so outputs stay glitch free
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            seq_clk_reg <= 1'b0;
            state_reg   <= ATS_IDLE;
            idx_reg     <= `ATS_IDX_ZERO;
        end else begin
            seq_clk_reg <= seq_clk;
            state_reg   <= state_next;
            idx_reg     <= idx_next;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_tap_en    <= '0;
            rx_tap_en    <= '0;
            test_pins_on <= 1'b0;
            test_mode    <= 1'b0;
            seq_done     <= 1'b0;
        end else begin
            tx_tap_en    <= sel.tx_sel;
            rx_tap_en    <= sel.rx_sel;
            test_pins_on <= any_tap;
            test_mode    <= seq_activ;
            seq_done     <= (state_reg == ATS_DONE);
        end
    end
endmodule : ats_seq

// File: ats_seq_properties.sv
// checker on the test pin sequencer ports
// assumes tester phases of two clocks or more
module ats_seq_props #(parameter int NUM_CH = 14) (
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic              seq_clk,
    input wire logic              seq_ctl_n,
    input wire logic [NUM_CH-1:0] tx_tap_en,
    input wire logic [NUM_CH-1:0] rx_tap_en,
    input wire logic              test_pins_on,
    input wire logic              test_mode,
    input wire logic              seq_done
);
    logic       sck_reg;
    logic [5:0] cnt_reg;
    wire        fall = sck_reg & ~seq_clk & ~seq_ctl_n;
    always_ff @(posedge clock) begin
        sck_reg <= !sys_rst && seq_clk;
        cnt_reg <= (sys_rst || seq_ctl_n) ? 6'h00 : cnt_reg + 6'(fall && cnt_reg < 6'h3F);
    end
    ////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    chk_first_fall: assert property (
        fall && cnt_reg == 0 |-> ##2 test_mode && !test_pins_on) else $error("first fall");
    chk_tx_zero: assert property (
        fall && cnt_reg == 1 |-> ##2 tx_tap_en == 1 && rx_tap_en == 0) else $error("tx ch0");
    chk_rx_zero: assert property (
        fall && cnt_reg == 16 |-> ##2 rx_tap_en == 1 && tx_tap_en == 0) else $error("rx ch0");
    chk_tap_map: assert property (
        // two clocks on, cnt_reg already holds the number of this fall
        fall && cnt_reg < 30 |-> ##2 tx_tap_en == (cnt_reg inside {[2:15]} ? 1 << (cnt_reg - 2) : 0)
        && rx_tap_en == (cnt_reg inside {[17:30]} ? 1 << (cnt_reg - 17) : 0)) else $error("map");
    chk_release_all: assert property (
        $rose(seq_ctl_n) |-> ##3 tx_tap_en == 0 && rx_tap_en == 0 && !test_mode && !seq_done)
        else $error("release");
    chk_held_idle: assert property (
        seq_ctl_n [*4] |-> !test_mode && !test_pins_on) else $error("held idle");
    chk_pins_any: assert property (
        test_pins_on == (|tx_tap_en || |rx_tap_en)) else $error("pins on");
endmodule : ats_seq_props
bind ats_seq ats_seq_props #(.NUM_CH(NUM_CH)) u_props (.clock, .sys_rst, .seq_clk, .seq_ctl_n,
    .tx_tap_en, .rx_tap_en, .test_pins_on, .test_mode, .seq_done);

// File: ats_seq_test.sv
// self-checking bench for the test pin sequencer
// assumes the checker binds itself
module ats_seq_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, sys_rst, seq_clk, seq_ctl_n, test_pins_on, test_mode, seq_done;
    logic [13:0] tx_tap_en, rx_tap_en;
    logic        pc = 1'b1;
    int          mismatches, checks_done, nf, wt, cyc, n;
    ats_seq dut (.clock, .sys_rst, .seq_clk, .seq_ctl_n, .tx_tap_en, .rx_tap_en,
        .test_pins_on, .test_mode, .seq_done);
    ats_tester tst (.clock, .seq_clk, .seq_ctl_n);
    function automatic logic [13:0] etap(int k, int b);
        return (k >= b && k < b + 14) ? 14'h1 << (k - b) : 14'h0;
    endfunction : etap
    task automatic chk(string s, logic [13:0] e, logic [13:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    ////////////////
    // checks three clocks after each fall, before the next can come
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            stop_test;
        end
        if (wt == 1) begin
            chk("tx", etap(nf, 2), tx_tap_en);
            chk("rx", etap(nf, 17), rx_tap_en);
            chk("flags", {11'h0, nf > 30, |{etap(nf, 2), etap(nf, 17)}, 1'b1},
                {11'h0, seq_done, test_pins_on, test_mode});
        end
        wt = (wt > 0) ? wt - 1 : 0;
        if (seq_ctl_n)
            nf = 0;
        else if (pc && !seq_clk) begin
            nf++;
            wt = 3;
        end
        pc = seq_clk;
    end
    initial begin
        sys_rst = 1'b1;
        void'($urandom(6399));
        repeat (8) @(posedge clock);
        #1 sys_rst = 1'b0;
        for (int t = 0; t < 7; t++) begin
            // the tester may only release control after the thirtieth pulse
            n = (t == 0) ? 31 : (t == 1) ? 30 : 30 + $urandom % 4;
            tst.run(n, 3 + $urandom % 4);
            repeat (4) @(posedge clock);
            chk("idle", 14'h0, {11'h0, test_mode, test_pins_on, seq_done});
            chk("idle_taps", 14'h0, tx_tap_en | rx_tap_en);
            $display("test %0d done after %0d falls", t, n);
        end
        stop_test;
    end
endmodule : ats_seq_test

// File: ats_tester.sv
// board tester model: sequence clock and control
// assumes one run call at a time
module ats_tester (
    input wire logic clock,
    output logic     seq_clk,
    output logic     seq_ctl_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        seq_clk = 1'b1;
        seq_ctl_n = 1'b1;
    end
    // clock stands high outside a run; steps never skipped
    task automatic run(input int n, input int h);
        @(posedge clock);
        #1 seq_ctl_n = 1'b0;
        repeat (n) begin
            repeat (h) @(posedge clock);
            #1 seq_clk = 1'b0;
            repeat (h) @(posedge clock);
            #1 seq_clk = 1'b1;
        end
        repeat (h) @(posedge clock);
        #1 seq_ctl_n = 1'b1;
    endtask : run
endmodule : ats_tester
